// [src/tic_defines.vh]
// Constants for the timer interrupt clear block
`ifndef TIC_DEFINES_VH
`define TIC_DEFINES_VH

// Register bus geometry
`define TIC_ADDR_W       12
`define TIC_DATA_W       32
`define TIC_NFLAG        7

// Register byte offsets
`define TIC_OFS_MASK     12'h018
`define TIC_OFS_RAW      12'h01C
`define TIC_OFS_MASKED   12'h020
`define TIC_OFS_CLEAR    12'h024

// Bit positions in the 32-bit register layout
`define TIC_BIT_A_TO     0
`define TIC_BIT_A_CM     1
`define TIC_BIT_A_CE     2
`define TIC_BIT_RTC      3
`define TIC_BIT_B_TO     8
`define TIC_BIT_B_CM     9
`define TIC_BIT_B_CE     10

// Flag indices in the packed internal vector
`define TIC_F_A_TO       0
`define TIC_F_A_CM       1
`define TIC_F_A_CE       2
`define TIC_F_RTC        3
`define TIC_F_B_TO       4
`define TIC_F_B_CM       5
`define TIC_F_B_CE       6

// Reset values
`define TIC_ZERO32       32'h0000_0000
`define TIC_FLAG_RST     7'h00
`define TIC_MASK_RST     7'h00

`endif

// [src/tic_flag_bank.v]
// Sticky interrupt flags with set-over-clear priority
`timescale 1ns/1ps
`include "tic_defines.vh"

module tic_flag_bank #(
	parameter W = `TIC_NFLAG
) (
	input  wire         mclk,
	input  wire         reset_n,
	input  wire [W-1:0] set_in,
	input  wire [W-1:0] clr_in,
	output reg  [W-1:0] flags_r
);

	wire [W-1:0] flags_nxt;

	assign flags_nxt = (flags_r & ~clr_in) | set_in;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			flags_r <= {W{1'b0}};
		end else begin
			flags_r <= flags_nxt;
		end
	end

endmodule // tic_flag_bank

// [src/tic_rdata_reg.v]
// Read data register, valid only in the cycle after a read
`timescale 1ns/1ps
`include "tic_defines.vh"

module tic_rdata_reg #(
	parameter DW = `TIC_DATA_W
) (
	input  wire          mclk,
	input  wire          reset_n,
	input  wire          rd_en,
	input  wire [DW-1:0] rd_data_nxt,
	output reg  [DW-1:0] rdata_r
);

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_r <= {DW{1'b0}};
		end else if (rd_en) begin
			rdata_r <= rd_data_nxt;
		end else begin
			rdata_r <= {DW{1'b0}};
		end
	end

endmodule // tic_rdata_reg

// [src/tic_top.v]
// Timer interrupt status, mask and write-one-to-clear logic
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
`include "tic_defines.vh"

module tic_top (
	input  wire                   mclk,
	input  wire                   reset_n,
	input  wire [`TIC_ADDR_W-1:0] reg_addr,
	input  wire [`TIC_DATA_W-1:0] reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output wire [`TIC_DATA_W-1:0] reg_rdata,
	input  wire                   evt_half_a_timeout,
	input  wire                   evt_half_a_capture_match,
	input  wire                   evt_half_a_capture_event,
	input  wire                   evt_rtc,
	input  wire                   evt_half_b_timeout,
	input  wire                   evt_half_b_capture_match,
	input  wire                   evt_half_b_capture_event,
	output wire                   irq
);

	////////////////////////////////////////////////////////////////////////////
	// Layout helpers

	function [`TIC_DATA_W-1:0] pack_flags;
		input [`TIC_NFLAG-1:0] f;
		begin
			pack_flags                = `TIC_ZERO32;
			pack_flags[`TIC_BIT_A_TO] = f[`TIC_F_A_TO];
			pack_flags[`TIC_BIT_A_CM] = f[`TIC_F_A_CM];
			pack_flags[`TIC_BIT_A_CE] = f[`TIC_F_A_CE];
			pack_flags[`TIC_BIT_RTC]  = f[`TIC_F_RTC];
			pack_flags[`TIC_BIT_B_TO] = f[`TIC_F_B_TO];
			pack_flags[`TIC_BIT_B_CM] = f[`TIC_F_B_CM];
			pack_flags[`TIC_BIT_B_CE] = f[`TIC_F_B_CE];
		end
	endfunction

	// Reserved positions are dropped here
	function [`TIC_NFLAG-1:0] unpack_word;
		input [`TIC_DATA_W-1:0] w;
		begin
			unpack_word              = `TIC_FLAG_RST;
			unpack_word[`TIC_F_A_TO] = w[`TIC_BIT_A_TO];
			unpack_word[`TIC_F_A_CM] = w[`TIC_BIT_A_CM];
			unpack_word[`TIC_F_A_CE] = w[`TIC_BIT_A_CE];
			unpack_word[`TIC_F_RTC]  = w[`TIC_BIT_RTC];
			unpack_word[`TIC_F_B_TO] = w[`TIC_BIT_B_TO];
			unpack_word[`TIC_F_B_CM] = w[`TIC_BIT_B_CM];
			unpack_word[`TIC_F_B_CE] = w[`TIC_BIT_B_CE];
		end
	endfunction

	function addr_hit;
		input [`TIC_ADDR_W-1:0] a;
		input [`TIC_ADDR_W-1:0] ofs;
		begin
			addr_hit = (a == ofs);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	reg  [`TIC_NFLAG-1:0]  mask_r;
	wire [`TIC_NFLAG-1:0]  raw_flags;
	wire [`TIC_NFLAG-1:0]  masked_flags;
	wire [`TIC_NFLAG-1:0]  evt_vec;
	wire [`TIC_NFLAG-1:0]  clr_vec;
	wire                   wr_clear;
	wire                   wr_mask;
	reg  [`TIC_DATA_W-1:0] rd_mux;

	////////////////////////////////////////////////////////////////////////////
	// Event gathering

	assign evt_vec[`TIC_F_A_TO] = evt_half_a_timeout;
	assign evt_vec[`TIC_F_A_CM] = evt_half_a_capture_match;
	assign evt_vec[`TIC_F_A_CE] = evt_half_a_capture_event;
	assign evt_vec[`TIC_F_RTC]  = evt_rtc;
	assign evt_vec[`TIC_F_B_TO] = evt_half_b_timeout;
	assign evt_vec[`TIC_F_B_CM] = evt_half_b_capture_match;
	assign evt_vec[`TIC_F_B_CE] = evt_half_b_capture_event;

	////////////////////////////////////////////////////////////////////////////
	// Write decode

	assign wr_clear = reg_wr & addr_hit(reg_addr, `TIC_OFS_CLEAR);
	assign wr_mask  = reg_wr & addr_hit(reg_addr, `TIC_OFS_MASK);

	assign clr_vec = wr_clear ? unpack_word(reg_wdata) : `TIC_FLAG_RST;

	always @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mask_r <= `TIC_MASK_RST;
		end else if (wr_mask) begin
			mask_r <= unpack_word(reg_wdata);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Flags and interrupt

	tic_flag_bank #(
		.W       (`TIC_NFLAG)
	) u_flags (
		.mclk    (mclk),
		.reset_n (reset_n),
		.set_in  (evt_vec),
		.clr_in  (clr_vec),
		.flags_r (raw_flags)
	);

	assign masked_flags = raw_flags & mask_r;
	assign irq          = |masked_flags;

	////////////////////////////////////////////////////////////////////////////
	// Read path

	always @* begin
		rd_mux = `TIC_ZERO32;
		case (reg_addr)
			`TIC_OFS_MASK:   rd_mux = pack_flags(mask_r);
			`TIC_OFS_RAW:    rd_mux = pack_flags(raw_flags);
			`TIC_OFS_MASKED: rd_mux = pack_flags(masked_flags);
			`TIC_OFS_CLEAR:  rd_mux = `TIC_ZERO32;
			default:         rd_mux = `TIC_ZERO32;
		endcase
	end

	tic_rdata_reg #(
		.DW          (`TIC_DATA_W)
	) u_rdata (
		.mclk        (mclk),
		.reset_n     (reset_n),
		.rd_en       (reg_rd),
		.rd_data_nxt (rd_mux),
		.rdata_r     (reg_rdata)
	);

endmodule // tic_top

// [tb/tic_top_props.sv]
// Assertion checker for the timer interrupt clear block
`timescale 1ns/1ps
module tic_top_props (
	input wire        mclk,
	input wire        reset_n,
	input wire [11:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire        reg_rd,
	input wire [31:0] reg_rdata,
	input wire        evt_half_a_timeout,
	input wire        evt_half_a_capture_match,
	input wire        evt_half_a_capture_event,
	input wire        evt_rtc,
	input wire        evt_half_b_timeout,
	input wire        evt_half_b_capture_match,
	input wire        evt_half_b_capture_event,
	input wire        irq
);
	wire [10:0] evl = {evt_half_b_capture_event, evt_half_b_capture_match, evt_half_b_timeout,
		4'h0, evt_rtc, evt_half_a_capture_event, evt_half_a_capture_match, evt_half_a_timeout};
	wire clr = reg_wr && reg_addr == 12'h024;
	default clocking @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_idle_rd_zero:
		assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000) else $error("idle rdata");
	a_resv_read_zero:
		assert property (reg_rdata[31:11] == 21'h00_0000 && reg_rdata[7:4] == 4'h0)
		else $error("reserved bits");
	a_clr_bits_gone:
		assert property (clr && evl == 0 ##1 evl == 0 ##1 reg_rd && reg_addr == 12'h01C && evl == 0
			|=> (reg_rdata[10:0] & $past(reg_wdata[10:0], 3)) == 11'h000) else $error("clear");
	a_evt_sets_flag:
		assert property (reg_rd && reg_addr == 12'h01C
			|=> (reg_rdata[10:0] & $past(evl, 2)) == $past(evl, 2)) else $error("event lost");
	a_masked_view:
		assert property (reg_rd && reg_addr == 12'h020 |=> (reg_rdata != 32'h0000_0000) == $past(irq))
		else $error("masked view");
	a_irq_rise_cause:
		assert property ($rose(irq) |-> $past(|evl) || $past(reg_wr && reg_addr == 12'h018))
		else $error("irq rise");
	a_zero_keeps:
		assert property (clr && reg_wdata[10:8] == 3'h0 && reg_wdata[3:0] == 4'h0 && irq |=> irq)
		else $error("zero write");
	a_clr_all_low:
		assert property (clr && (reg_wdata[10:0] & 11'h70F) == 11'h70F && evl == 0 |=> !irq)
		else $error("clear all");
endmodule // tic_top_props

// [tb/tb.sv]
// Self-checking testbench for the timer interrupt clear block
`timescale 1ns/1ps
module tb;
	reg         mclk = 0;
	reg         reset_n = 0;
	reg         reg_wr = 0;
	reg         reg_rd = 0;
	reg  [11:0] reg_addr = 12'h000;
	reg  [31:0] reg_wdata = 32'h0000_0000;
	reg  [6:0]  ev = 7'h00;
	reg  [31:0] b;
	wire [31:0] reg_rdata;
	wire        irq;
	integer     failures = 0;
	integer     n_compared = 0;
	integer     i;
	tic_top tic_top_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.evt_half_a_timeout(ev[0]), .evt_half_a_capture_match(ev[1]),
		.evt_half_a_capture_event(ev[2]), .evt_rtc(ev[3]), .evt_half_b_timeout(ev[4]),
		.evt_half_b_capture_match(ev[5]), .evt_half_b_capture_event(ev[6]), .irq(irq));
	always #5 mclk = ~mclk;
	task chk(input [39:0] nm, input [31:0] exp, input [31:0] got);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("[ERR] %0s exp %h got %h", nm, exp, got);
			end
		end
	endtask
	task wr(input [11:0] a, input [31:0] d);
		begin
			@(posedge mclk);
			reg_wr <= 1'b1;
			reg_addr <= a;
			reg_wdata <= d;
			@(posedge mclk);
			reg_wr <= 1'b0;
			#1;
		end
	endtask
	task rd(input [11:0] a, input [31:0] exp);
		begin
			@(posedge mclk);
			reg_rd <= 1'b1;
			reg_addr <= a;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 chk("rdata", exp, reg_rdata);
		end
	endtask
	task pulse(input [6:0] e, input [31:0] c);
		begin
			@(posedge mclk);
			ev <= e;
			reg_wr <= |c;
			reg_addr <= 12'h024;
			reg_wdata <= c;
			@(posedge mclk);
			ev <= 7'h00;
			reg_wr <= 1'b0;
		end
	endtask
	task t_flags;
		begin
			wr(12'h018, 32'h0000_070F);
			for (i = 0; i < 7; i = i + 1) begin
				b = (i < 4) ? 32'h0000_0001 << i : 32'h0000_0001 << (i + 4);
				pulse(7'h01 << i, 32'h0000_0000);
				rd(12'h020, b);
				wr(12'h024, 32'hFFFF_F8F0 | (~b & 32'h0000_070F));
				rd(12'h01C, b);
				wr(12'h024, b);
				chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
				rd(12'h020, 32'h0000_0000);
			end
			$display("t_flags done");
		end
	endtask
	task t_race;
		begin
			wr(12'h018, 32'h0000_0000);
			pulse(7'h08, 32'h0000_0008);
			rd(12'h01C, 32'h0000_0008);
			rd(12'h020, 32'h0000_0000);
			wr(12'h018, 32'h0000_0008);
			chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
			rd(12'h018, 32'h0000_0008);
			wr(12'h024, 32'hFFFF_F8F0);
			chk("irq", 32'h0000_0001, {31'h0000_0000, irq});
			wr(12'h024, 32'hFFFF_FFFF);
			chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
			wr(12'h100, 32'hFFFF_FFFF);
			rd(12'h100, 32'h0000_0000);
			rd(12'h024, 32'h0000_0000);
			@(posedge mclk);
			ev <= 7'h08;
			@(posedge mclk);
			ev <= 7'h00;
			reg_rd <= 1'b1;
			reg_addr <= 12'h01C;
			@(posedge mclk);
			reg_rd <= 1'b0;
			#1 chk("rdata", 32'h0000_0008, reg_rdata);
			wr(12'h024, 32'h0000_0008);
			$display("t_race done");
		end
	endtask
	task final_report;
		begin
			$display("compared %0d failures %0d", n_compared, failures);
			if (failures == 0 && n_compared > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		reset_n <= 1'b1;
		t_flags;
		t_race;
		final_report;
	end
	initial begin
		#100000;
		failures = failures + 1;
		final_report;
	end
endmodule // tb
bind tic_top tic_top_props tic_top_props_i (.mclk(mclk), .reset_n(reset_n),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .evt_half_a_timeout(evt_half_a_timeout),
	.evt_half_a_capture_match(evt_half_a_capture_match),
	.evt_half_a_capture_event(evt_half_a_capture_event), .evt_rtc(evt_rtc),
	.evt_half_b_timeout(evt_half_b_timeout), .evt_half_b_capture_match(evt_half_b_capture_match),
	.evt_half_b_capture_event(evt_half_b_capture_event), .irq(irq));
